// ### include/pmc_pkg.sv
// Package of constants and types for the power mode controller
package pmc_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [11:0] OFS_POWER_MODE_CONTROL    = 12'h032;
    localparam logic [11:0] OFS_WAKE_EVENT_ENABLE     = 12'h034;
    localparam logic [11:0] OFS_GLOBAL_RESET_CONTROL  = 12'h126;
    localparam logic [11:0] OFS_INTERRUPT_ENABLE      = 12'h190;
    localparam logic [11:0] OFS_REGULATOR_CONTROL     = 12'h748;
    localparam logic [11:0] OFS_SLEEP_DELAY_SETTING   = 12'h04C;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int MODE_LSB         = 0;
    localparam int WAKE_STATUS_BIT  = 4;
    localparam int WAKE_PIN_EN_BIT  = 0;
    localparam int ENERGY_IRQ_BIT   = 2;
    localparam int REG_OFF_BIT      = 7;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [15:0] RST_WORD          = 16'h0000;
    localparam logic [7:0]  RST_SLEEP_DELAY   = 8'h10;
    // ****************************************
    // Mode codes
    // ****************************************
    localparam logic [1:0] MODE_NORMAL  = 2'h0;
    localparam logic [1:0] MODE_ENERGY  = 2'h1;
    localparam logic [1:0] MODE_SOFT_PD = 2'h2;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS     = 40;
    localparam int WAKE_ENERGY_NS    = 100;
    localparam int WAKE_ENERGY_CYC   = (WAKE_ENERGY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SLEEP_UNIT_CYC    = 256;
    typedef enum logic [1:0] {ST_NORMAL, ST_ENERGY_ON, ST_ENERGY_LOW, ST_SOFT_PD} pmc_state_t;
endpackage

// ### verilog/pmc_counter.sv
// Saturating cycle counter with clear
module pmc_counter
    import pmc_pkg::*;
#(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    // Control
    input  wire logic         i_clear,
    input  wire logic         i_run,
    // Count
    output logic [W-1:0]      o_count
);
    typedef struct packed {
        logic [W-1:0] count;
    } pmc_cnt_t;
    pmc_cnt_t r;
    pmc_cnt_t next_r;
    always_comb begin
        next_r = r;
        if (i_clear || !i_run) begin
            next_r.count = '0;
        end else if (r.count != {W{1'b1}}) begin
            next_r.count = r.count + 1'b1;
        end
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
    assign o_count = r.count;
endmodule

// ### verilog/pmc_power_mode_controller.sv
// Power mode controller: mode decode, energy sleep/wake, soft power-down
// Operation
// - Decode mode field 00/01/10 from normal mode; energy mode stores 10 without entering soft power-down
// - Reset gives normal mode, field zero
// - Normal mode: clocks, PHY, MAC on
// - No energy past go-sleep time: low power
// - Low power keeps only energy detect on
// - Energy over 100 ns wakes to full power, energy mode kept
// - Energy event drives wake pin if enabled
// - Energy event raises interrupt if enabled
// - Read of global reset register wakes device
// - Fiber mode disables energy sleep/wake
// - Soft power-down stops clocks, PHY, MAC
// - Soft power-down defaults all but the regulator control register
// - Writing 00 leaves soft power-down
// - Straps resampled on soft power-down exit
// - Regulator-off bit resets 0, 1 turns off
module pmc_power_mode_controller
    import pmc_pkg::*;
(
    // Clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_RST,
    // Host register port
    input  wire logic        i_RD,
    input  wire logic        i_WR,
    input  wire logic [11:0] i_ADDR,
    input  wire logic [15:0] i_WDATA,
    output logic [15:0]      o_RDATA,
    // Link and straps
    input  wire logic        i_ENERGY,
    input  wire logic        i_FIBER,
    input  wire logic [7:0]  i_STRAPS,
    // Power controls
    output logic             o_PLL_EN,
    output logic             o_PHY_EN,
    output logic             o_MAC_EN,
    output logic             o_RX_ENERGY_EN,
    output logic             o_HOST_EN,
    output logic             o_SOFT_RESET,
    output logic             o_REG_OFF,
    output logic [7:0]       o_STRAP_LATCH,
    // Wake signals
    output logic             o_POWER_EVENT,
    output logic             o_IRQ
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        pmc_state_t  st;
        logic [1:0]  mode;
        logic        wake_status;
        logic [15:0] wake_enable;
        logic [15:0] irq_enable;
        logic [15:0] reg_ctrl;
        logic [7:0]  sleep_delay;
        logic [15:0] rdata;
        logic        pll_en;
        logic        phy_en;
        logic        mac_en;
        logic        rx_en;
        logic        host_en;
        logic        soft_reset;
        logic        power_event;
        logic        irq;
        logic        strap_req;
        logic [7:0]  straps;
    } pmc_reg_t;
    pmc_reg_t r;
    pmc_reg_t next_r;
    logic [15:0] idle_cnt;
    logic [15:0] energy_cnt;
    logic        sleep_due;
    logic        wake_due;
    logic        wr_mode;
    logic        rd_wake;
    logic [1:0]  eff_mode;
    // ****************************************
    // Timers
    // ****************************************
    pmc_counter #(.W(16)) u_idle (
        .i_clk   (I_CLK),
        .i_rst   (I_RST),
        .i_clear (r.st != ST_ENERGY_ON),
        .i_run   (!i_ENERGY),
        .o_count (idle_cnt)
    );
    pmc_counter #(.W(16)) u_energy (
        .i_clk   (I_CLK),
        .i_rst   (I_RST),
        .i_clear (r.st != ST_ENERGY_LOW),
        .i_run   (i_ENERGY),
        .o_count (energy_cnt)
    );
    assign sleep_due = (idle_cnt >= 16'({r.sleep_delay, 8'h00})) && !i_FIBER;
    assign wake_due  = (energy_cnt >= 16'(WAKE_ENERGY_CYC)) && !i_FIBER;
    assign wr_mode   = i_WR && (i_ADDR == OFS_POWER_MODE_CONTROL);
    assign rd_wake   = i_RD && (i_ADDR == OFS_GLOBAL_RESET_CONTROL);
    // Mode 11 falls back to normal
    assign eff_mode  = (i_WDATA[1:0] == 2'h3) ? MODE_NORMAL : i_WDATA[1:0];
    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_r = r;
        next_r.soft_reset = 1'b0;
        next_r.strap_req  = 1'b0;
        next_r.power_event = 1'b0;
        next_r.irq        = 1'b0;
        // Register writes, blocked in soft power-down except mode
        if (i_WR && r.st != ST_SOFT_PD) begin
            unique case (i_ADDR)
                OFS_WAKE_EVENT_ENABLE:   next_r.wake_enable = i_WDATA;
                OFS_INTERRUPT_ENABLE:    next_r.irq_enable  = i_WDATA;
                OFS_REGULATOR_CONTROL:   next_r.reg_ctrl    = i_WDATA;
                OFS_SLEEP_DELAY_SETTING: next_r.sleep_delay = i_WDATA[7:0];
                OFS_POWER_MODE_CONTROL:  if (i_WDATA[WAKE_STATUS_BIT]) begin
                    next_r.wake_status = 1'b0;
                end
                default: ;
            endcase
        end
        unique case (r.st)
            ST_NORMAL: begin
                if (wr_mode) begin
                    next_r.mode = eff_mode;
                    if (eff_mode == MODE_ENERGY) begin
                        next_r.st = ST_ENERGY_ON;
                    end else if (eff_mode == MODE_SOFT_PD) begin
                        next_r.st         = ST_SOFT_PD;
                        next_r.soft_reset = 1'b1;
                        next_r.wake_enable = RST_WORD;
                        next_r.irq_enable  = RST_WORD;
                        next_r.sleep_delay = RST_SLEEP_DELAY;
                        next_r.wake_status = 1'b0;
                    end
                end
            end
            ST_ENERGY_ON: begin
                if (wr_mode) begin
                    next_r.mode = eff_mode;
                    if (eff_mode == MODE_NORMAL) begin
                        next_r.st = ST_NORMAL;
                    end
                end else if (sleep_due) begin
                    next_r.st = ST_ENERGY_LOW;
                end
            end
            ST_ENERGY_LOW: begin
                if (rd_wake || wake_due) begin
                    next_r.st = ST_ENERGY_ON;
                end
                // Energy event flagged even when a wake read lands together
                if (wake_due) begin
                    next_r.wake_status = 1'b1;
                    next_r.power_event = r.wake_enable[WAKE_PIN_EN_BIT];
                    next_r.irq         = r.irq_enable[ENERGY_IRQ_BIT];
                end
            end
            ST_SOFT_PD: begin
                if (wr_mode && i_WDATA[1:0] == MODE_NORMAL) begin
                    next_r.mode      = MODE_NORMAL;
                    next_r.st        = ST_NORMAL;
                    next_r.strap_req = 1'b1;
                end
            end
        endcase
        // Event pins hold until the host wake read or any write to the mode register
        if (r.power_event && !(rd_wake || wr_mode)) begin
            next_r.power_event = 1'b1;
        end
        if (r.irq && !(rd_wake || wr_mode)) begin
            next_r.irq = 1'b1;
        end
        if (r.strap_req) begin
            next_r.straps = i_STRAPS;
        end
        // Block enables from the next state
        next_r.pll_en  = (next_r.st == ST_NORMAL) || (next_r.st == ST_ENERGY_ON);
        next_r.phy_en  = next_r.pll_en;
        next_r.mac_en  = next_r.pll_en;
        next_r.host_en = next_r.pll_en;
        next_r.rx_en   = next_r.st != ST_SOFT_PD;
        // Read data
        next_r.rdata = RST_WORD;
        if (i_RD) begin
            unique case (i_ADDR)
                OFS_POWER_MODE_CONTROL: begin
                    next_r.rdata[1:0] = r.mode;
                    next_r.rdata[WAKE_STATUS_BIT] = r.wake_status;
                end
                OFS_WAKE_EVENT_ENABLE:   next_r.rdata = r.wake_enable;
                OFS_INTERRUPT_ENABLE:    next_r.rdata = r.irq_enable;
                OFS_REGULATOR_CONTROL:   next_r.rdata = r.reg_ctrl;
                OFS_SLEEP_DELAY_SETTING: next_r.rdata = {8'h00, r.sleep_delay};
                default: next_r.rdata = RST_WORD;
            endcase
        end
    end
    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            r             <= '0;
            r.st          <= ST_NORMAL;
            r.mode        <= MODE_NORMAL;
            r.sleep_delay <= RST_SLEEP_DELAY;
            r.reg_ctrl    <= RST_WORD;
            r.pll_en      <= 1'b1;
            r.phy_en      <= 1'b1;
            r.mac_en      <= 1'b1;
            r.host_en     <= 1'b1;
            r.rx_en       <= 1'b1;
            r.strap_req   <= 1'b1;
        end else begin
            r <= next_r;
        end
    end
    assign o_RDATA        = r.rdata;
    assign o_PLL_EN       = r.pll_en;
    assign o_PHY_EN       = r.phy_en;
    assign o_MAC_EN       = r.mac_en;
    assign o_HOST_EN      = r.host_en;
    assign o_RX_ENERGY_EN = r.rx_en;
    assign o_SOFT_RESET   = r.soft_reset;
    assign o_REG_OFF      = r.reg_ctrl[REG_OFF_BIT];
    assign o_STRAP_LATCH  = r.straps;
    assign o_POWER_EVENT  = r.power_event;
    assign o_IRQ          = r.irq;
    // ****************************************
    // Checks
    // ****************************************
    property p_rst_normal;
        @(posedge I_CLK) $fell(I_RST) |-> (r.mode == MODE_NORMAL) && o_PLL_EN;
    endproperty
    a_rst_normal: assert property (p_rst_normal) else $error("not normal after reset");
    property p_mode_11;
        @(posedge I_CLK) disable iff (I_RST)
        (r.st == ST_NORMAL && wr_mode && i_WDATA[1:0] == 2'h3) |=> r.st == ST_NORMAL;
    endproperty
    a_mode_11: assert property (p_mode_11) else $error("mode 11 left normal");
    property p_pd_off;
        @(posedge I_CLK) disable iff (I_RST)
        (r.st == ST_SOFT_PD) |-> !o_PLL_EN && !o_PHY_EN && !o_MAC_EN;
    endproperty
    a_pd_off: assert property (p_pd_off) else $error("blocks on in power-down");
    property p_pd_reset;
        @(posedge I_CLK) disable iff (I_RST)
        (r.st == ST_NORMAL && wr_mode && eff_mode == MODE_SOFT_PD) |=>
            o_SOFT_RESET && r.wake_enable == RST_WORD;
    endproperty
    a_pd_reset: assert property (p_pd_reset) else $error("no default on power-down");
    property p_pd_exit;
        @(posedge I_CLK) disable iff (I_RST)
        (r.st == ST_SOFT_PD && wr_mode && i_WDATA[1:0] == MODE_NORMAL) |=>
            r.st == ST_NORMAL ##1 o_STRAP_LATCH == $past(i_STRAPS);
    endproperty
    a_pd_exit: assert property (p_pd_exit) else $error("bad power-down exit");
    property p_low_only_rx;
        @(posedge I_CLK) disable iff (I_RST)
        (r.st == ST_ENERGY_LOW) |-> !o_PLL_EN && !o_MAC_EN && o_RX_ENERGY_EN;
    endproperty
    a_low_only_rx: assert property (p_low_only_rx) else $error("low power enables wrong");
    property p_wake_energy;
        @(posedge I_CLK) disable iff (I_RST)
        (r.st == ST_ENERGY_LOW && !i_FIBER && !i_RD) ##1 (i_ENERGY && !i_RD)[*4]
            |=> r.st == ST_ENERGY_ON;
    endproperty
    a_wake_energy: assert property (p_wake_energy) else $error("no energy wake");
    property p_wake_read;
        @(posedge I_CLK) disable iff (I_RST)
        (r.st == ST_ENERGY_LOW && rd_wake) |=> r.st == ST_ENERGY_ON;
    endproperty
    a_wake_read: assert property (p_wake_read) else $error("read did not wake");
    property p_power_event;
        @(posedge I_CLK) disable iff (I_RST)
        (r.st == ST_ENERGY_LOW && wake_due && !rd_wake) |=>
            o_POWER_EVENT == $past(r.wake_enable[WAKE_PIN_EN_BIT])
            && o_IRQ == $past(r.irq_enable[ENERGY_IRQ_BIT]);
    endproperty
    a_power_event: assert property (p_power_event) else $error("wake outputs wrong");
    property p_fiber;
        @(posedge I_CLK) disable iff (I_RST)
        (r.st == ST_ENERGY_ON && i_FIBER && !wr_mode) |=> r.st == ST_ENERGY_ON;
    endproperty
    a_fiber: assert property (p_fiber) else $error("sleep in fiber mode");
endmodule

// ### bench/pmc_host_model.sv
// Host processor model driving the register port
module pmc_host_model
    import pmc_pkg::*;
(
    // Clock
    input  wire logic        i_clk,
    // Register port
    output logic             o_rd,
    output logic             o_wr,
    output logic [11:0]      o_addr,
    output logic [15:0]      o_wdata,
    input  wire logic [15:0] i_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_rd    = 1'b0;
        o_wr    = 1'b0;
        o_addr  = 12'hFFF;
        o_wdata = 16'hFFFF;
    end
    // ****************************************
    // Bus cycles
    // ****************************************
    // One word write, mode changes included
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge i_clk);
        o_wr    <= 1'b1;
        o_addr  <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr    <= 1'b0;
        o_addr  <= ~a;
        o_wdata <= ~d;
    endtask
    // One word read, also the wake-up read
    task automatic rd(input logic [11:0] a, output logic [15:0] d);
        @(posedge i_clk);
        o_rd   <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_rd   <= 1'b0;
        o_addr <= ~a;
        #1;
        d = i_rdata;
    endtask
endmodule

// ### bench/pmc_power_mode_controller_tb.sv
// Testbench of the power mode controller
module pmc_power_mode_controller_tb
    import pmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        I_CLK;
    logic        I_RST;
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        energy;
    logic        fiber;
    logic [7:0]  straps;
    logic        pll;
    logic        phy;
    logic        mac;
    logic        rxen;
    logic        host_en;
    logic        soft_rst;
    logic        reg_off;
    logic [7:0]  strap_latch;
    logic        power_event;
    logic        irq;
    logic [15:0] rv;
    int          failures = 0;
    int          compares = 0;
    int          soft_pulses = 0;

    pmc_power_mode_controller pmc_power_mode_controller_inst (
        .I_CLK(I_CLK), .I_RST(I_RST), .i_RD(rd), .i_WR(wr), .i_ADDR(addr),
        .i_WDATA(wdata), .o_RDATA(rdata), .i_ENERGY(energy), .i_FIBER(fiber),
        .i_STRAPS(straps), .o_PLL_EN(pll), .o_PHY_EN(phy), .o_MAC_EN(mac),
        .o_RX_ENERGY_EN(rxen), .o_HOST_EN(host_en), .o_SOFT_RESET(soft_rst),
        .o_REG_OFF(reg_off), .o_STRAP_LATCH(strap_latch), .o_POWER_EVENT(power_event),
        .o_IRQ(irq));
    pmc_host_model pmc_host_model_inst (
        .i_clk(I_CLK), .o_rd(rd), .o_wr(wr), .o_addr(addr), .o_wdata(wdata),
        .i_rdata(rdata));

    // ****************************************
    // Helpers
    // ****************************************
    initial begin
        I_CLK = 1'b0;
        forever #20 I_CLK = ~I_CLK;
    end
    always @(posedge I_CLK) begin
        if (soft_rst === 1'b1) begin
            soft_pulses++;
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic [11:0] a, input logic [15:0] exp);
        pmc_host_model_inst.rd(a, rv);
        chk(rv, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge I_CLK);
        #1;
    endtask
    task automatic pulse(input int n);
        @(posedge I_CLK);
        energy <= 1'b1;
        repeat (n) @(posedge I_CLK);
        energy <= 1'b0;
    endtask
    function automatic logic [15:0] pw();
        return {11'h000, pll, phy, mac, host_en, rxen};
    endfunction
    task automatic conclude();
        if (failures == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #(40 * 5000);
        failures++;
        conclude();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        I_RST  = 1'b1;
        energy = 1'b1;
        fiber  = 1'b0;
        straps = 8'hA5;
        repeat (16) @(posedge I_CLK);
        I_RST <= 1'b0;
        cyc(3);
        chk(pw(), 16'h001F);
        chk({8'h00, strap_latch}, 16'h00A5);
        rchk(OFS_POWER_MODE_CONTROL, RST_WORD);
        rchk(OFS_WAKE_EVENT_ENABLE, RST_WORD);
        rchk(OFS_INTERRUPT_ENABLE, RST_WORD);
        rchk(OFS_REGULATOR_CONTROL, RST_WORD);
        rchk(OFS_SLEEP_DELAY_SETTING, {8'h00, RST_SLEEP_DELAY});
        rchk(12'h7FE, 16'h0000);
        pmc_host_model_inst.wr(OFS_REGULATOR_CONTROL, 16'h0080);
        cyc(1);
        chk({15'h0000, reg_off}, 16'h0001);
        // Unused code with no energy must not sleep
        pmc_host_model_inst.wr(OFS_SLEEP_DELAY_SETTING, 16'h0001);
        energy <= 1'b0;
        pmc_host_model_inst.wr(OFS_POWER_MODE_CONTROL, 16'h0003);
        cyc(300);
        chk(pw(), 16'h001F);
        pmc_host_model_inst.wr(OFS_POWER_MODE_CONTROL, {14'h0000, MODE_NORMAL});
        // Energy sleep and wake
        pmc_host_model_inst.wr(OFS_WAKE_EVENT_ENABLE, 16'h0001);
        pmc_host_model_inst.wr(OFS_INTERRUPT_ENABLE, 16'h0004);
        pmc_host_model_inst.wr(OFS_POWER_MODE_CONTROL, {14'h0000, MODE_ENERGY});
        cyc(200);
        chk(pw(), 16'h001F);
        cyc(100);
        chk(pw(), 16'h0001);
        pulse(2);
        cyc(5);
        chk(pw(), 16'h0001);
        chk({14'h0000, power_event, irq}, 16'h0000);
        pulse(4);
        cyc(1);
        chk(pw(), 16'h001F);
        chk({14'h0000, power_event, irq}, 16'h0003);
        rchk(OFS_POWER_MODE_CONTROL, 16'h0011);
        pmc_host_model_inst.rd(OFS_GLOBAL_RESET_CONTROL, rv);
        cyc(1);
        chk({14'h0000, power_event, irq}, 16'h0000);
        cyc(300);
        chk(pw(), 16'h0001);
        pmc_host_model_inst.rd(OFS_GLOBAL_RESET_CONTROL, rv);
        cyc(1);
        chk(pw(), 16'h001F);
        @(posedge I_CLK) fiber <= 1'b1;
        cyc(300);
        chk(pw(), 16'h001F);
        pmc_host_model_inst.wr(OFS_POWER_MODE_CONTROL, {14'h0000, MODE_NORMAL});
        fiber <= 1'b0;
        // Soft power-down and exit
        pmc_host_model_inst.wr(OFS_POWER_MODE_CONTROL, {14'h0000, MODE_SOFT_PD});
        cyc(2);
        chk(pw(), 16'h0000);
        chk(soft_pulses[15:0], 16'h0001);
        @(posedge I_CLK) straps <= 8'h3C;
        pmc_host_model_inst.wr(OFS_WAKE_EVENT_ENABLE, 16'h0001);
        cyc(2);
        chk({8'h00, strap_latch}, 16'h00A5);
        pmc_host_model_inst.wr(OFS_POWER_MODE_CONTROL, {14'h0000, MODE_NORMAL});
        cyc(3);
        chk(pw(), 16'h001F);
        chk({8'h00, strap_latch}, 16'h003C);
        rchk(OFS_WAKE_EVENT_ENABLE, RST_WORD);
        rchk(OFS_INTERRUPT_ENABLE, RST_WORD);
        rchk(OFS_SLEEP_DELAY_SETTING, {8'h00, RST_SLEEP_DELAY});
        rchk(OFS_REGULATOR_CONTROL, 16'h0080);
        conclude();
    end
endmodule
